// ===== hw/eeprom_slave_consts.vh
// constants for the two-wire serial eeprom slave
`ifndef EEPROM_SLAVE_CONSTS_VH
`define EEPROM_SLAVE_CONSTS_VH
`define DEV_TYPE      4'ha
`define ADDR_W        16
`define PAGE_BITS     7
`define PAGE_HI_W     9
`define BYTE_BITS     4'h8
`define BIT_CNT_ZERO  4'h0
`define BIT_CNT_ONE   4'h1
`define COPY_W        8
`define COPY_END      8'h80
`define T_WR_MS       5
`define KHZ_PER_MHZ   1000
`define CLK_MHZ       200
`define FIFO_DEPTH    8
`define FIFO_PTR_W    3
`define PIN_SYNC_W    6
`endif

// ===== hw/pin_sync.v
// two flip-flop synchroniser for asynchronous pin inputs
`timescale 1ns/1ps
module pin_sync #(
  parameter W = 1
) (
  input  wire         clk_in,
  input  wire         rst_n_in,
  input  wire [W-1:0] async_in,
  output wire [W-1:0] sync_out
);
  reg [W-1:0] meta_reg;
  reg [W-1:0] stable_reg;

  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      meta_reg   <= {W{1'b0}};
      stable_reg <= {W{1'b0}};
    end else begin
      meta_reg   <= async_in;
      stable_reg <= meta_reg;
    end
  end

  assign sync_out = stable_reg;
endmodule

// ===== hw/byte_fifo.v
// synchronous fifo with valid/ready on both sides
`timescale 1ns/1ps
module byte_fifo #(
  parameter WIDTH = 15,
  parameter DEPTH = 8,
  parameter PTR_W = 3
) (
  input  wire             clk_in,
  input  wire             rst_n_in,
  input  wire             in_valid_in,
  output wire             in_ready_out,
  input  wire [WIDTH-1:0] in_data_in,
  output wire             out_valid_out,
  input  wire             out_ready_in,
  output wire [WIDTH-1:0] out_data_out
);
  reg [WIDTH-1:0] store [0:DEPTH-1];
  reg [PTR_W-1:0] wr_ptr_reg;
  reg [PTR_W-1:0] rd_ptr_reg;
  reg [PTR_W:0]   count_reg;
  wire            push;
  wire            pop;

  assign in_ready_out  = (count_reg != DEPTH[PTR_W:0]);
  assign out_valid_out = (count_reg != {(PTR_W+1){1'b0}});
  assign push          = in_valid_in & in_ready_out;
  assign pop           = out_valid_out & out_ready_in;
  assign out_data_out  = store[rd_ptr_reg];

  always @(posedge clk_in) begin
    if (push) begin
      store[wr_ptr_reg] <= in_data_in;
    end
  end

  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      wr_ptr_reg <= {PTR_W{1'b0}};
      rd_ptr_reg <= {PTR_W{1'b0}};
      count_reg  <= {(PTR_W+1){1'b0}};
    end else begin
      if (push) begin
        wr_ptr_reg <= (wr_ptr_reg == DEPTH[PTR_W-1:0] - 1'b1) ? {PTR_W{1'b0}} : wr_ptr_reg + 1'b1;
      end
      if (pop) begin
        rd_ptr_reg <= (rd_ptr_reg == DEPTH[PTR_W-1:0] - 1'b1) ? {PTR_W{1'b0}} : rd_ptr_reg + 1'b1;
      end
      if (push & ~pop) begin
        count_reg <= count_reg + 1'b1;
      end else if (pop & ~push) begin
        count_reg <= count_reg - 1'b1;
      end
    end
  end
endmodule

// ===== hw/two_wire_serial_eeprom_slave.v
// two-wire serial eeprom slave: bus protocol, page buffer and memory array
`timescale 1ns/1ps
`include "eeprom_slave_consts.vh"

module two_wire_serial_eeprom_slave #(
  parameter WRITE_CYCLES = `T_WR_MS * `KHZ_PER_MHZ * `CLK_MHZ,
  parameter FIFO_DEPTH   = `FIFO_DEPTH
) (
  input  wire clk_in,
  input  wire rst_n_in,
  input  wire scl_in,
  input  wire sda_in,
  input  wire chip_select_bit2_in,
  input  wire chip_select_bit1_in,
  input  wire chip_select_bit0_in,
  input  wire write_protect_in,
  output wire sda_out,
  output wire sda_oe_out,
  output wire busy_out,
  output wire standby_out
);
  localparam ST_IDLE = 4'h0;
  localparam ST_DEV  = 4'h1;
  localparam ST_AHI  = 4'h2;
  localparam ST_ALO  = 4'h3;
  localparam ST_WDAT = 4'h4;
  localparam ST_ACK  = 4'h5;
  localparam ST_TX   = 4'h6;
  localparam ST_RACK = 4'h7;
  localparam ST_PROG = 4'h8;
  localparam ENTRY_W = `PAGE_BITS + 8;
  localparam PAGE_N  = 1 << `PAGE_BITS;
  localparam MEM_N   = 1 << `ADDR_W;

  reg  [7:0]            mem [0:MEM_N-1];
  reg  [7:0]            page_latch [0:PAGE_N-1];

  reg  [3:0]            state_reg;
  reg  [3:0]            after_ack_reg;
  reg  [3:0]            bit_cnt_reg;
  reg  [7:0]            shift_reg;
  reg  [7:0]            addr_hi_reg;
  reg  [`ADDR_W-1:0]    addr_reg;
  reg                   write_mode_reg;
  reg                   have_data_reg;
  reg                   master_ack_reg;
  reg                   push_reg;
  reg  [PAGE_N-1:0]     valid_reg;
  reg                   copying_reg;
  reg  [`COPY_W-1:0]    copy_cnt_reg;
  reg  [31:0]           prog_cnt_reg;
  reg                   scl_d_reg;
  reg                   sda_d_reg;
  reg                   sda_oe_reg;
  reg                   sda_out_reg;
  reg                   busy_reg;
  reg                   standby_reg;

  wire [`PIN_SYNC_W-1:0] pins_s;
  wire                  scl_s;
  wire                  sda_s;
  wire [2:0]            cs_s;
  wire                  wp_s;
  wire                  scl_rise;
  wire                  scl_fall;
  wire                  start_cond;
  wire                  stop_cond;
  wire                  byte_in_done;
  wire                  dev_match;
  wire [7:0]            rd_byte;
  wire                  fifo_in_ready;
  wire                  fifo_out_valid;
  wire [ENTRY_W-1:0]    fifo_out_data;
  wire                  drain_ready;
  wire                  copy_we;

  // low 7 bits advance, page bits stay
  function [`ADDR_W-1:0] page_inc;
    input [`ADDR_W-1:0] a;
    begin
      page_inc = {a[`ADDR_W-1:`PAGE_BITS], a[`PAGE_BITS-1:0] + 1'b1};
    end
  endfunction

  pin_sync #(
    .W (`PIN_SYNC_W)
  ) u_pin_sync (
    .clk_in   (clk_in),
    .rst_n_in (rst_n_in),
    .async_in ({scl_in, sda_in, chip_select_bit2_in, chip_select_bit1_in, chip_select_bit0_in, write_protect_in}),
    .sync_out (pins_s)
  );

  assign scl_s = pins_s[5];
  assign sda_s = pins_s[4];
  assign cs_s  = pins_s[3:1];
  assign wp_s  = pins_s[0];

  assign scl_rise   = scl_s & ~scl_d_reg;
  assign scl_fall   = ~scl_s & scl_d_reg;
  assign start_cond = scl_s & scl_d_reg & sda_d_reg & ~sda_s;
  assign stop_cond  = scl_s & scl_d_reg & ~sda_d_reg & sda_s;

  assign byte_in_done = scl_fall & (bit_cnt_reg == `BYTE_BITS);
  assign dev_match    = (shift_reg[7:4] == `DEV_TYPE) & (shift_reg[3:1] == cs_s);
  assign rd_byte      = mem[addr_reg];

  byte_fifo #(
    .WIDTH (ENTRY_W),
    .DEPTH (FIFO_DEPTH),
    .PTR_W (`FIFO_PTR_W)
  ) u_byte_fifo (
    .clk_in        (clk_in),
    .rst_n_in      (rst_n_in),
    .in_valid_in   (push_reg),
    .in_ready_out  (fifo_in_ready),
    .in_data_in    ({addr_reg[`PAGE_BITS-1:0], shift_reg}),
    .out_valid_out (fifo_out_valid),
    .out_ready_in  (drain_ready),
    .out_data_out  (fifo_out_data)
  );

  // the page latch is frozen while it is being committed to the array
  assign drain_ready = ~copying_reg;
  assign copy_we     = copying_reg & ~copy_cnt_reg[`COPY_W-1] & valid_reg[copy_cnt_reg[`PAGE_BITS-1:0]] & ~wp_s;

  always @(posedge clk_in) begin
    if (fifo_out_valid & drain_ready) begin
      page_latch[fifo_out_data[ENTRY_W-1:8]] <= fifo_out_data[7:0];
    end
  end

  // the byte is replaced whole, no erase step is visible outside
  always @(posedge clk_in) begin
    if (copy_we) begin
      mem[{addr_reg[`ADDR_W-1:`PAGE_BITS], copy_cnt_reg[`PAGE_BITS-1:0]}] <=
        page_latch[copy_cnt_reg[`PAGE_BITS-1:0]];
    end
  end

  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_reg      <= ST_IDLE;
      after_ack_reg  <= ST_IDLE;
      bit_cnt_reg    <= `BIT_CNT_ZERO;
      shift_reg      <= 8'h00;
      addr_hi_reg    <= 8'h00;
      addr_reg       <= {`ADDR_W{1'b0}};
      write_mode_reg <= 1'b0;
      have_data_reg  <= 1'b0;
      master_ack_reg <= 1'b0;
      push_reg       <= 1'b0;
      valid_reg      <= {PAGE_N{1'b0}};
      copying_reg    <= 1'b0;
      copy_cnt_reg   <= {`COPY_W{1'b0}};
      prog_cnt_reg   <= 32'h0000_0000;
      scl_d_reg      <= 1'b0;
      sda_d_reg      <= 1'b0;
      sda_oe_reg     <= 1'b0;
      sda_out_reg    <= 1'b0;
      busy_reg       <= 1'b0;
      standby_reg    <= 1'b1;
    end else begin
      scl_d_reg   <= scl_s;
      sda_d_reg   <= sda_s;
      sda_out_reg <= 1'b0;
      push_reg    <= 1'b0;
      standby_reg <= (state_reg == ST_IDLE);
      if (fifo_out_valid & drain_ready) begin
        valid_reg[fifo_out_data[ENTRY_W-1:8]] <= 1'b1;
      end
      if (state_reg == ST_PROG) begin
        // bus is not watched at all until the cycle ends
        sda_oe_reg   <= 1'b0;
        prog_cnt_reg <= prog_cnt_reg + 32'h0000_0001;
        if (~copying_reg & ~fifo_out_valid & ~copy_cnt_reg[`COPY_W-1]) begin
          copying_reg <= 1'b1;
        end
        if (copying_reg & ~copy_cnt_reg[`COPY_W-1]) begin
          copy_cnt_reg <= copy_cnt_reg + 1'b1;
        end
        if (prog_cnt_reg == WRITE_CYCLES - 1) begin
          state_reg   <= ST_IDLE;
          busy_reg    <= 1'b0;
          copying_reg <= 1'b0;
          valid_reg   <= {PAGE_N{1'b0}};
        end
      end else if (start_cond) begin
        // a repeated start drops any page that was being gathered
        state_reg      <= ST_DEV;
        bit_cnt_reg    <= `BIT_CNT_ZERO;
        sda_oe_reg     <= 1'b0;
        write_mode_reg <= 1'b0;
        have_data_reg  <= 1'b0;
        valid_reg      <= {PAGE_N{1'b0}};
      end else if (stop_cond) begin
        sda_oe_reg <= 1'b0;
        // a write with data and no protection starts the timed cycle
        if (write_mode_reg & have_data_reg & ~wp_s) begin
          state_reg    <= ST_PROG;
          busy_reg     <= 1'b1;
          prog_cnt_reg <= 32'h0000_0000;
          copy_cnt_reg <= {`COPY_W{1'b0}};
        end else begin
          state_reg <= ST_IDLE;
          valid_reg <= {PAGE_N{1'b0}};
        end
      end else begin
        case (state_reg)
          ST_DEV, ST_AHI, ST_ALO, ST_WDAT: begin
            if (scl_rise & (bit_cnt_reg != `BYTE_BITS)) begin
              shift_reg   <= {shift_reg[6:0], sda_s};
              bit_cnt_reg <= bit_cnt_reg + 1'b1;
            end else if (byte_in_done) begin
              bit_cnt_reg <= `BIT_CNT_ZERO;
              case (state_reg)
                ST_DEV: begin
                  if (dev_match) begin
                    sda_oe_reg     <= 1'b1;
                    write_mode_reg <= ~shift_reg[0];
                    after_ack_reg  <= shift_reg[0] ? ST_TX : ST_AHI;
                    state_reg      <= ST_ACK;
                  end else begin
                    state_reg <= ST_IDLE;
                  end
                end
                ST_AHI: begin
                  addr_hi_reg   <= shift_reg;
                  sda_oe_reg    <= 1'b1;
                  after_ack_reg <= ST_ALO;
                  state_reg     <= ST_ACK;
                end
                ST_ALO: begin
                  addr_reg      <= {addr_hi_reg, shift_reg};
                  sda_oe_reg    <= 1'b1;
                  after_ack_reg <= ST_WDAT;
                  state_reg     <= ST_ACK;
                end
                default: begin
                  if (fifo_in_ready) begin
                    // protected data is still acknowledged, stop then skips programming
                    push_reg      <= 1'b1;
                    have_data_reg <= 1'b1;
                    sda_oe_reg    <= 1'b1;
                    after_ack_reg <= ST_WDAT;
                    state_reg     <= ST_ACK;
                  end else begin
                    state_reg <= ST_IDLE;
                  end
                end
              endcase
            end
          end
          ST_ACK: begin
            if (scl_rise & (after_ack_reg == ST_ALO | after_ack_reg == ST_AHI)) begin
              bit_cnt_reg <= `BIT_CNT_ZERO;
            end
            // push_reg lasts one cycle, so the queued byte moves the pointer here
            if (push_reg) begin
              addr_reg <= page_inc(addr_reg);
            end
            if (scl_fall) begin
              if (after_ack_reg == ST_TX) begin
                shift_reg   <= rd_byte;
                sda_oe_reg  <= ~rd_byte[7];
                bit_cnt_reg <= `BIT_CNT_ONE;
              end else begin
                sda_oe_reg <= 1'b0;
              end
              state_reg <= after_ack_reg;
            end
          end
          // bits leave msb first, each one after a clock fall
          ST_TX: begin
            if (scl_fall) begin
              if (bit_cnt_reg == `BYTE_BITS) begin
                sda_oe_reg <= 1'b0;
                addr_reg   <= addr_reg + 1'b1;
                state_reg  <= ST_RACK;
              end else begin
                sda_oe_reg  <= ~shift_reg[6];
                shift_reg   <= {shift_reg[6:0], 1'b0};
                bit_cnt_reg <= bit_cnt_reg + 1'b1;
              end
            end
          end
          // master answer is taken on the ninth rise, acted on at its fall
          ST_RACK: begin
            if (scl_rise) begin
              master_ack_reg <= ~sda_s;
            end else if (scl_fall) begin
              if (master_ack_reg) begin
                shift_reg   <= rd_byte;
                sda_oe_reg  <= ~rd_byte[7];
                bit_cnt_reg <= `BIT_CNT_ONE;
                state_reg   <= ST_TX;
              end else begin
                state_reg <= ST_IDLE;
              end
            end
          end
          // idle waits for the next start with the line released
          default: begin
            sda_oe_reg <= 1'b0;
          end
        endcase
      end
    end
  end

  assign sda_out     = sda_out_reg;
  assign sda_oe_out  = sda_oe_reg;
  assign busy_out    = busy_reg;
  assign standby_out = standby_reg;
endmodule

// ===== testbench/two_wire_serial_eeprom_slave_chk.sv
// assertions on the pins of the two-wire serial eeprom slave
`timescale 1ns/1ps
module two_wire_serial_eeprom_slave_chk #(
  parameter WRITE_CYCLES = 1000000
) (
  input wire clk_in,
  input wire rst_n_in,
  input wire scl_in,
  input wire sda_in,
  input wire write_protect_in,
  input wire sda_out,
  input wire sda_oe_out,
  input wire busy_out,
  input wire standby_out
);
  logic [31:0] busy_cnt;
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  // length of the current self-timed write cycle
  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in)
      busy_cnt <= 32'h0;
    else
      busy_cnt <= busy_out ? busy_cnt + 32'h1 : 32'h0;
  end
  sequence s_start;
    scl_in && $fell(sda_in);
  endsequence
  sequence s_stop;
    scl_in && $rose(sda_in);
  endsequence
  a_open_drain: assert property (sda_out == 1'b0) else $error("data pin driven high");
  a_drive_scl_low: assert property ($changed(sda_oe_out) |-> !scl_in)
    else $error("data changed with clock high");
  a_ack_stands: assert property ($rose(scl_in) && sda_oe_out |=> sda_oe_out [*6])
    else $error("drive released during clock high");
  a_start_quiet: assert property (s_start |=> !sda_oe_out [*8]) else $error("drive after start");
  a_stop_settles: assert property (s_stop |-> ##[1:8] (busy_out || standby_out))
    else $error("no standby or write after stop");
  a_busy_silent: assert property (busy_out |-> !sda_oe_out) else $error("answer while busy");
  a_busy_bound: assert property (busy_cnt <= WRITE_CYCLES + 2) else $error("write cycle too long");
  a_busy_from_stop: assert property ($rose(busy_out) |-> scl_in && sda_in && !write_protect_in)
    else $error("write cycle without stop");
  a_wake_standby: assert property ($fell(busy_out) |-> ##[0:2] standby_out)
    else $error("no standby after write");
  a_busy_awake: assert property (busy_out && $past(busy_out) |-> !standby_out)
    else $error("standby while busy");
endmodule
bind two_wire_serial_eeprom_slave two_wire_serial_eeprom_slave_chk #(.WRITE_CYCLES(WRITE_CYCLES)) chk (
  .clk_in(clk_in), .rst_n_in(rst_n_in), .scl_in(scl_in), .sda_in(sda_in), .write_protect_in(write_protect_in),
  .sda_out(sda_out), .sda_oe_out(sda_oe_out), .busy_out(busy_out), .standby_out(standby_out));

// ===== testbench/i2c_master_model.sv
// bus master model driving the clock and open-drain data line
`timescale 1ns/1ps
module i2c_master_model (
  input  wire  clk_in,
  input  wire  sda_line_in,
  output logic scl_out,
  output logic sda_rel_out
);
  initial begin
    scl_out = 1'b1;
    sda_rel_out = 1'b1;
  end
  task automatic w(input int n);
    repeat (n) @(posedge clk_in);
  endtask
  task automatic start();
    w(5);
    sda_rel_out <= 1'b1;
    w(5);
    scl_out <= 1'b1;
    w(5);
    sda_rel_out <= 1'b0;
    w(5);
    scl_out <= 1'b0;
  endtask
  task automatic stop();
    w(5);
    sda_rel_out <= 1'b0;
    w(5);
    scl_out <= 1'b1;
    w(5);
    sda_rel_out <= 1'b1;
  endtask
  // data moves only while the clock is low
  task automatic bitx(input logic b, output logic r);
    w(5);
    sda_rel_out <= b;
    w(5);
    scl_out <= 1'b1;
    w(10);
    r = sda_line_in;
    scl_out <= 1'b0;
  endtask
  task automatic wbyte(input logic [7:0] v, output logic ack);
    logic x;
    for (int i = 7; i >= 0; i--) bitx(v[i], x);
    bitx(1'b1, ack);
  endtask
  task automatic rbyte(input logic nack, output logic [7:0] v);
    logic x;
    for (int i = 7; i >= 0; i--) bitx(1'b1, v[i]);
    bitx(nack, x);
  endtask
endmodule

// ===== testbench/tb_two_wire_serial_eeprom_slave.sv
// testbench for the two-wire serial eeprom slave
`timescale 1ns/1ps
module tb_two_wire_serial_eeprom_slave;
  localparam int WC = 600;
  logic       clk_in = 1'b0;
  logic       rst_n_in = 1'b0;
  logic [2:0] cs = 3'h5;
  logic       wp = 1'b0;
  logic       scl, sda_rel, sda_out, sda_oe_out, busy_out, standby_out, r;
  logic [7:0] d;
  int         fails = 0;
  int         tests_run = 0;
  wire        sda_line = sda_oe_out ? 1'b0 : sda_rel;
  always #2.5 clk_in = ~clk_in;
  two_wire_serial_eeprom_slave #(.WRITE_CYCLES(WC)) uut (
    .clk_in(clk_in), .rst_n_in(rst_n_in), .scl_in(scl), .sda_in(sda_line),
    .chip_select_bit2_in(cs[2]), .chip_select_bit1_in(cs[1]), .chip_select_bit0_in(cs[0]),
    .write_protect_in(wp), .sda_out(sda_out), .sda_oe_out(sda_oe_out), .busy_out(busy_out),
    .standby_out(standby_out));
  i2c_master_model m (.clk_in(clk_in), .sda_line_in(sda_line), .scl_out(scl), .sda_rel_out(sda_rel));
  task automatic final_report;
    if (fails == 0 && tests_run > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic hdr(input logic [15:0] a);
    m.start();
    m.wbyte(8'haa, r);
    chk_bit(r, 1'b0);
    m.wbyte(a[15:8], r);
    chk_bit(r, 1'b0);
    m.wbyte(a[7:0], r);
    chk_bit(r, 1'b0);
  endtask
  task automatic wr(input logic [15:0] a, input int n, input logic [23:0] v);
    hdr(a);
    for (int i = 0; i < n; i++) begin
      m.wbyte(v[8*i +: 8], r);
      chk_bit(r, 1'b0);
    end
    m.stop();
  endtask
  task automatic rs(input int n, input logic [23:0] e);
    m.start();
    m.wbyte(8'hab, r);
    chk_bit(r, 1'b0);
    for (int i = 0; i < n; i++) begin
      m.rbyte(i == n - 1, d);
      chk_byte(d, e[8*i +: 8]);
    end
    m.stop();
    repeat (8) @(posedge clk_in);
    chk_bit(standby_out, 1'b1);
  endtask
  // stop, then poll during the write cycle and wait it out
  task automatic t_wait_busy;
    int i;
    i = 0;
    repeat (6) @(posedge clk_in);
    chk_bit(busy_out, 1'b1);
    m.start();
    m.wbyte(8'haa, r);
    chk_bit(r, 1'b1);
    m.stop();
    while (busy_out === 1'b1 && i < WC) begin
      @(posedge clk_in);
      i++;
    end
    chk_bit(busy_out, 1'b0);
    repeat (3) @(posedge clk_in);
    chk_bit(standby_out, 1'b1);
  endtask
  // page write crossing the page end, reads wrapping the whole array
  task automatic t_write_read;
    wr(16'h0000, 1, 24'h00005a);
    t_wait_busy();
    wr(16'hfffe, 3, 24'h332211);
    t_wait_busy();
    hdr(16'hfffe);
    rs(2, 24'h002211);
    rs(1, 24'h00005a);
    hdr(16'hff80);
    rs(1, 24'h000033);
  endtask
  task automatic t_bad_addr;
    logic [7:0] bad [4] = '{8'ha0, 8'hba, 8'h2a, 8'ha8};
    foreach (bad[i]) begin
      m.start();
      m.wbyte(bad[i], r);
      chk_bit(r, 1'b1);
      m.stop();
    end
    cs <= 3'h2;
    m.start();
    m.wbyte(8'ha4, r);
    chk_bit(r, 1'b0);
    m.stop();
    repeat (6) @(posedge clk_in);
    chk_bit(busy_out, 1'b0);
    cs <= 3'h5;
  endtask
  task automatic t_protect;
    wp <= 1'b1;
    wr(16'h0000, 1, 24'h0000c3);
    repeat (6) @(posedge clk_in);
    chk_bit(busy_out, 1'b0);
    wp <= 1'b0;
    hdr(16'h0000);
    rs(1, 24'h00005a);
  endtask
  initial begin
    repeat (10) @(posedge clk_in);
    rst_n_in <= 1'b1;
    repeat (4) @(posedge clk_in);
    chk_bit(standby_out, 1'b1);
    chk_bit(sda_oe_out, 1'b0);
    chk_bit(sda_out, 1'b0);
    t_write_read();
    t_bad_addr();
    t_protect();
    final_report();
  end
  initial begin
    #400000;
    fails++;
    final_report();
  end
endmodule
